// *** rtl/tfc_map.vh ***
// register map, field positions and reset values of the timer freeze control bank
`ifndef TFC_MAP_VH
`define TFC_MAP_VH
`define TFC_ADDR_W 32
`define TFC_DATA_W 16
`define TFC_OFS_FREEZE_SET 32'h50003300
`define TFC_OFS_FREEZE_CLEAR 32'h50003302
`define TFC_OFS_DEBUG_POLICY 32'h50003304
`define TFC_OFS_SYS_STATUS 32'h50003306
`define TFC_OFS_SYS_CONTROL 32'h50003308
`define TFC_OFS_RADIO_SAMPLE 32'h5000330a
`define TFC_BIT_WAKEUP 0
`define TFC_BIT_SWTIM 1
`define TFC_BIT_RADIO 2
`define TFC_BIT_WDOG 3
`define TFC_BIT_DMA 4
`define TFC_HOLD_W 5
`define TFC_BIT_STOP_ALL 0
`define TFC_BIT_CAL_PHASE 0
`define TFC_RST_HOLD 5'h00
`define TFC_RST_STOP_ALL 1'h1
`define TFC_RST_CAL_PHASE 1'h0
`define TFC_RST_STATUS_SPARE 1'h0
`endif

// *** rtl/tfc_sync3.v ***
// three-stage input synchroniser; output changes once stages two and three agree
`default_nettype none
module tfc_sync3 (
  input wire clk, // system clock
  input wire resetn, // synchronous reset, active low
  input wire din, // asynchronous level
  output reg dout // filtered level
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  always @(posedge clk) begin
    if (!resetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule // tfc_sync3
`default_nettype wire

// *** rtl/tfc_freeze_gate.v ***
// combines hold flags with debug-halt policy into per-target freeze requests
`default_nettype none
`include "tfc_map.vh"
module tfc_freeze_gate (
  input wire clk, // system clock
  input wire resetn, // synchronous reset, active low
  input wire [`TFC_HOLD_W-1:0] hold, // software hold flags
  input wire stop_all, // debug halt freezes every timer
  input wire halted, // core halted in debug, synchronised
  input wire wdog_nmi_sel, // watchdog interrupt-or-reset select, synchronised
  output reg [`TFC_HOLD_W-1:0] freeze // freeze requests to targets
);
  reg [`TFC_HOLD_W-1:0] freeze_next;
  always @* begin
    freeze_next = hold;
    if (halted && stop_all) begin
      freeze_next = {`TFC_HOLD_W{1'b1}};
    end
    // with stop_all clear a halted core leaves non-watchdog targets on their flags
    if (halted) begin
      freeze_next[`TFC_BIT_WDOG] = 1'b1;
    end else if (wdog_nmi_sel) begin
      // software hold is ignored while the watchdog selects reset/nmi
      freeze_next[`TFC_BIT_WDOG] = 1'b0;
    end
  end
  always @(posedge clk) begin
    if (!resetn) begin
      freeze <= `TFC_RST_HOLD;
    end else begin
      freeze <= freeze_next;
    end
  end
endmodule // tfc_freeze_gate
`default_nettype wire

// *** rtl/tfc_top.v ***
// timer freeze control register bank: freeze flags, debug policy, status
//
// The implementer's own choice: strobed register access.
`default_nettype none
`include "tfc_map.vh"
module tfc_top #(
  parameter ADDR_W = `TFC_ADDR_W,
  parameter DATA_W = `TFC_DATA_W
) (
  input wire clk, // system clock, 20 MHz
  input wire resetn, // synchronous reset, active low
  input wire [ADDR_W-1:0] addr, // register byte address
  input wire [DATA_W-1:0] wdata, // write data
  input wire wr, // write strobe
  input wire rd, // read strobe
  output reg [DATA_W-1:0] rdata, // read data, valid the cycle after rd
  input wire core_halted, // core in debug halt, async level
  input wire wdog_nmi_sel, // watchdog interrupt-or-reset select, async level
  input wire cal_phase_in, // calibration phase indication, async level
  output reg dma_freeze, // freeze request to dma
  output reg wdog_freeze, // freeze request to watchdog
  output reg radio_clk_freeze, // stop request to radio master clock
  output reg swtim_freeze, // freeze request to software timer
  output reg wkup_freeze // freeze request to wake-up timer
);
  reg [`TFC_HOLD_W-1:0] hold_reg;
  reg [`TFC_HOLD_W-1:0] hold_next;
  reg debug_halt_stop_all_reg;
  reg [DATA_W-1:0] rdata_next;
  wire halted_s;
  wire nmi_sel_s;
  wire cal_phase_s;
  wire [`TFC_HOLD_W-1:0] freeze_w;
  wire hit_set;
  wire hit_clr;
  wire hit_dbg;
  wire hit_sts;
  wire dma_hold_bit;
  wire watchdog_hold_bit;
  wire radio_clock_hold_bit;
  wire software_timer_hold_bit;
  wire wakeup_timer_hold_bit;

  // exact compare: addresses outside the bank read zero and writes are dropped
  function addr_hit;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] ofs;
    begin
      addr_hit = (a == ofs);
    end
  endfunction

  function [DATA_W-1:0] zext_hold;
    input [`TFC_HOLD_W-1:0] v;
    begin
      zext_hold = {{(DATA_W-`TFC_HOLD_W){1'b0}}, v};
    end
  endfunction

  assign hit_set = addr_hit(addr, `TFC_OFS_FREEZE_SET);
  assign hit_clr = addr_hit(addr, `TFC_OFS_FREEZE_CLEAR);
  assign hit_dbg = addr_hit(addr, `TFC_OFS_DEBUG_POLICY);
  assign hit_sts = addr_hit(addr, `TFC_OFS_SYS_STATUS);

  tfc_sync3 u_sync_halt (
    .clk(clk),
    .resetn(resetn),
    .din(core_halted),
    .dout(halted_s)
  );

  tfc_sync3 u_sync_nmi (
    .clk(clk),
    .resetn(resetn),
    .din(wdog_nmi_sel),
    .dout(nmi_sel_s)
  );

  // calibration phase is a live status; it only changes in boot flow
  tfc_sync3 u_sync_cal (
    .clk(clk),
    .resetn(resetn),
    .din(cal_phase_in),
    .dout(cal_phase_s)
  );

  assign dma_hold_bit = wdata[`TFC_BIT_DMA];
  assign watchdog_hold_bit = wdata[`TFC_BIT_WDOG];
  assign radio_clock_hold_bit = wdata[`TFC_BIT_RADIO];
  assign software_timer_hold_bit = wdata[`TFC_BIT_SWTIM];
  assign wakeup_timer_hold_bit = wdata[`TFC_BIT_WAKEUP];

  // set-only and clear-only writes; zeros leave the flags alone
  always @* begin
    hold_next = hold_reg;
    if (wr && hit_set) begin
      hold_next[`TFC_BIT_DMA] = hold_reg[`TFC_BIT_DMA] | dma_hold_bit;
      hold_next[`TFC_BIT_WDOG] = hold_reg[`TFC_BIT_WDOG] | watchdog_hold_bit;
      hold_next[`TFC_BIT_RADIO] = hold_reg[`TFC_BIT_RADIO] | radio_clock_hold_bit;
      hold_next[`TFC_BIT_SWTIM] = hold_reg[`TFC_BIT_SWTIM] | software_timer_hold_bit;
      hold_next[`TFC_BIT_WAKEUP] = hold_reg[`TFC_BIT_WAKEUP] | wakeup_timer_hold_bit;
    end else if (wr && hit_clr) begin
      hold_next = hold_reg & ~wdata[`TFC_HOLD_W-1:0];
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      hold_reg <= `TFC_RST_HOLD;
      debug_halt_stop_all_reg <= `TFC_RST_STOP_ALL;
    end else begin
      hold_reg <= hold_next;
      if (wr && hit_dbg) begin
        debug_halt_stop_all_reg <= wdata[`TFC_BIT_STOP_ALL];
      end
    end
  end

  tfc_freeze_gate u_gate (
    .clk(clk),
    .resetn(resetn),
    .hold(hold_reg),
    .stop_all(debug_halt_stop_all_reg),
    .halted(halted_s),
    .wdog_nmi_sel(nmi_sel_s),
    .freeze(freeze_w)
  );

  // set/clear registers read back the live hold flags so software can see them
  always @* begin
    rdata_next = {DATA_W{1'b0}};
    if (rd) begin
      if (hit_set || hit_clr) begin
        rdata_next = zext_hold(hold_reg);
      end else if (hit_dbg) begin
        rdata_next[`TFC_BIT_STOP_ALL] = debug_halt_stop_all_reg;
      end else if (hit_sts) begin
        // status bit 1 is reserved: it keeps no storage, so it reads zero and writes are dropped
        rdata_next[`TFC_BIT_CAL_PHASE] = cal_phase_s;
      end
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      rdata <= {DATA_W{1'b0}};
      dma_freeze <= 1'b0;
      wdog_freeze <= 1'b0;
      radio_clk_freeze <= 1'b0;
      swtim_freeze <= 1'b0;
      wkup_freeze <= 1'b0;
    end else begin
      rdata <= rdata_next;
      dma_freeze <= freeze_w[`TFC_BIT_DMA];
      wdog_freeze <= freeze_w[`TFC_BIT_WDOG];
      radio_clk_freeze <= freeze_w[`TFC_BIT_RADIO];
      swtim_freeze <= freeze_w[`TFC_BIT_SWTIM];
      wkup_freeze <= freeze_w[`TFC_BIT_WAKEUP];
    end
  end
endmodule // tfc_top
`default_nettype wire

// *** test/tfc_monitor.sv ***
// assertion checker for the timer freeze control bank
`default_nettype none
`include "tfc_map.vh"
module tfc_monitor (
  input wire logic clk, // system clock
  input wire logic resetn, // sync reset, active low
  input wire logic [31:0] addr, // address
  input wire logic [15:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [15:0] rdata, // read data
  input wire logic core_halted, // debug halt
  input wire logic wdog_nmi_sel, // watchdog select
  input wire logic cal_phase_in, // calibration phase
  input wire logic dma_freeze, // dma freeze
  input wire logic wdog_freeze, // watchdog freeze
  input wire logic radio_clk_freeze, // radio freeze
  input wire logic swtim_freeze, // sw timer freeze
  input wire logic wkup_freeze // wake-up freeze
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] run_reg;
  logic [3:0] halt_reg;
  wire set_w = wr && addr == `TFC_OFS_FREEZE_SET;
  wire clr_w = wr && addr == `TFC_OFS_FREEZE_CLEAR;
  // saturating run lengths, so the halt level has settled through the synchroniser
  always_ff @(posedge clk) begin
    run_reg <= (!resetn || core_halted) ? 4'h0 : run_reg + {3'h0, run_reg != 4'hf};
    halt_reg <= (!resetn || !core_halted) ? 4'h0 : halt_reg + {3'h0, halt_reg != 4'hf};
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  property p_rd_idle; !$past(rd) |-> rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero outside read");
  // flag, gate and output flops each take one edge, so the request is seen three edges on
  property p_dma; set_w && wdata[4] |-> ##3 dma_freeze; endproperty
  a_dma: assert property (p_dma) else $error("dma not frozen");
  property p_radio; set_w && wdata[2] |-> ##3 radio_clk_freeze; endproperty
  a_radio: assert property (p_radio) else $error("radio clock not stopped");
  property p_swtim; set_w && wdata[1] |-> ##3 swtim_freeze; endproperty
  a_swtim: assert property (p_swtim) else $error("software timer not frozen");
  property p_wkup; set_w && wdata[0] |-> ##3 wkup_freeze; endproperty
  a_wkup: assert property (p_wkup) else $error("wake-up timer not frozen");
  property p_clr; clr_w && wdata[4] && run_reg == 4'hf |-> ##3 !dma_freeze; endproperty
  a_clr: assert property (p_clr) else $error("dma not resumed");
  property p_halt; halt_reg == 4'hf |-> wdog_freeze; endproperty
  a_halt: assert property (p_halt) else $error("watchdog running in halt");
  property p_reset;
    $past(!resetn) |-> rdata == 16'h0000 && !dma_freeze && !wdog_freeze && !radio_clk_freeze
      && !swtim_freeze && !wkup_freeze;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_unmap; $past(rd) && $past(addr) == `TFC_OFS_SYS_CONTROL |-> rdata == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // tfc_monitor
bind tfc_top tfc_monitor u_mon (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .core_halted(core_halted), .wdog_nmi_sel(wdog_nmi_sel), .cal_phase_in(cal_phase_in),
  .dma_freeze(dma_freeze), .wdog_freeze(wdog_freeze), .radio_clk_freeze(radio_clk_freeze),
  .swtim_freeze(swtim_freeze), .wkup_freeze(wkup_freeze));
`default_nettype wire

// *** test/test_timer_freeze_control.sv ***
// self-checking bench for the timer freeze control bank
`default_nettype none
`include "tfc_map.vh"
module test_timer_freeze_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, resetn = 1'h0, wr = 1'h0, rd = 1'h0, halt = 1'h0, nmi = 1'h0, cal = 1'h0;
  logic [31:0] addr = 32'h0;
  logic [15:0] wdata = 16'h0;
  wire [15:0] rdata;
  wire [4:0] frz;
  int miscompares = 0, n_compared = 0;
  tfc_top dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .core_halted(halt), .wdog_nmi_sel(nmi), .cal_phase_in(cal), .dma_freeze(frz[4]), .wdog_freeze(frz[3]),
    .radio_clk_freeze(frz[2]), .swtim_freeze(frz[1]), .wkup_freeze(frz[0]));
  initial forever #25 clk = ~clk;
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wt(logic [31:0] a, logic [15:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rc(logic [31:0] a, logic [15:0] e);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1 chk("rdata", e, rdata);
  endtask
  // long enough for the three-flop synchroniser plus gate and output flops
  task automatic fc(logic [4:0] e);
    repeat (8) @(posedge clk);
    #1 chk("freeze", {11'h0, e}, {11'h0, frz});
    // return on a rising edge so pin changes that follow land on the edge
    @(posedge clk);
  endtask
  task automatic close_out;
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    rc(`TFC_OFS_FREEZE_SET, 16'h0000);
    rc(`TFC_OFS_FREEZE_CLEAR, 16'h0000);
    rc(`TFC_OFS_DEBUG_POLICY, 16'h0001);
    rc(`TFC_OFS_SYS_STATUS, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      wt(`TFC_OFS_FREEZE_SET, 16'h0001 << i);
      fc(5'h1f >> (4 - i));
    end
    wt(`TFC_OFS_FREEZE_SET, 16'hffe0);
    wt(`TFC_OFS_FREEZE_CLEAR, 16'h0000);
    fc(5'h1f);
    rc(`TFC_OFS_FREEZE_SET, 16'h001f);
    wt(`TFC_OFS_FREEZE_CLEAR, 16'h0014);
    rc(`TFC_OFS_FREEZE_CLEAR, 16'h000b);
    fc(5'h0b);
    nmi <= 1'h1;
    fc(5'h03);
    halt <= 1'h1;
    fc(5'h1f);
    wt(`TFC_OFS_DEBUG_POLICY, 16'hfffe);
    rc(`TFC_OFS_DEBUG_POLICY, 16'h0000);
    fc(5'h0b);
    wt(`TFC_OFS_FREEZE_CLEAR, 16'h001f);
    fc(5'h08);
    halt <= 1'h0;
    nmi <= 1'h0;
    cal <= 1'h1;
    fc(5'h00);
    rc(`TFC_OFS_SYS_STATUS, 16'h0001);
    wt(`TFC_OFS_SYS_STATUS, 16'h0002);
    rc(`TFC_OFS_SYS_STATUS, 16'h0001);
    wt(`TFC_OFS_SYS_CONTROL, 16'hffff);
    rc(`TFC_OFS_SYS_CONTROL, 16'h0000);
    rc(`TFC_OFS_RADIO_SAMPLE, 16'h0000);
    @(posedge clk);
    resetn <= 1'h0;
    cal <= 1'h0;
    @(posedge clk);
    resetn <= 1'h1;
    rc(`TFC_OFS_DEBUG_POLICY, 16'h0001);
    rc(`TFC_OFS_SYS_STATUS, 16'h0000);
    close_out();
  end
endmodule // test_timer_freeze_control
`default_nettype wire
